// File: hw/cmbf_pkg.sv
/*
 Constants and types shared by the core memory bus fabric.
 Assumes a single 50 MHz clock domain; all users import the whole package.
*/
package cmbf_pkg;
    // ==========================================================
    // Bus widths
    localparam int CMBF_PROG_AW = 21;
    localparam int CMBF_PROG_DW = 16;
    localparam int CMBF_DATA_AW = 24;
    localparam int CMBF_DATA_DW = 32;
    localparam int CMBF_SEC_DW = 16;
    localparam int CMBF_PERIPH_AW = 16;
    localparam int CMBF_PERIPH_DW = 16;

    // ==========================================================
    // Address map of the peripheral register window
    localparam logic [23:0] CMBF_PERIPH_BASE = 24'h00F000;
    localparam logic [23:0] CMBF_PERIPH_MASK = 24'hFFF000;
    localparam int CMBF_ADDR_MSB = 23;

    // ==========================================================
    // Reset values and read latency
    localparam logic [31:0] CMBF_DATA_RST = 32'h00000000;
    localparam logic [23:0] CMBF_ADDR_RST = 24'h000000;
    localparam int CMBF_READ_LAT = 2;

    // ==========================================================
    // Access sizes on the primary data address
    typedef enum logic [1:0]
    {
        CMBF_SIZE_BYTE = 2'h0,
        CMBF_SIZE_WORD = 2'h1,
        CMBF_SIZE_LONG = 2'h3
    } cmbf_size_type;
endpackage

// File: hw/cmbf_dec_if.sv
/*
 Carrier between the fabric top and its primary address decoder.
 Assumes both ends run on the fabric clock; purely combinational content.
*/
`timescale 1ns/100ps
interface cmbf_dec_if;
    import cmbf_pkg::*;
    logic [23:0] addr_raw;
    cmbf_size_type size;
    logic [23:0] addr_eff;
    logic is_periph;

    modport dec
    (
        input addr_raw,
        input size,
        output addr_eff,
        output is_periph
    );
    modport top
    (
        output addr_raw,
        output size,
        input addr_eff,
        input is_periph
    );
endinterface

// File: hw/cmbf_decode.sv
/*
 Primary data address decoder: byte-access address clamp and the
 memory versus peripheral register window select.
 Assumes the caller holds address and size stable for the request cycle.
*/
`timescale 1ns/100ps
module cmbf_decode
    import cmbf_pkg::*;
(
    cmbf_dec_if.dec dbus
);
    // ==========================================================
    // Address clamp and window decode
    wire is_byte = (dbus.size == CMBF_SIZE_BYTE);
    // Bytes live only in the lower half, so the top bit is cleared
    assign dbus.addr_eff = is_byte ?
        {1'b0, dbus.addr_raw[CMBF_ADDR_MSB-1:0]} : dbus.addr_raw;
    // Fixed window; everything outside it goes to data memory
    assign dbus.is_periph =
        ((dbus.addr_eff & CMBF_PERIPH_MASK) == CMBF_PERIPH_BASE);
endmodule

// File: hw/cmbf_fabric.sv
/*
 Core memory bus fabric: routes program fetch and write, primary data
 reads and writes (to data memory or the peripheral register bus) and
 the secondary word read of a dual read.
 Assumes one clock mclk; memories and peripherals present read data in
 the cycle their read strobe is high; core requests are one-cycle pulses.
*/
`timescale 1ns/100ps
module cmbf_fabric
    import cmbf_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [20:0] prog_addr,
    input wire logic prog_rd,
    input wire logic prog_wr,
    output logic [15:0] prog_read_data,
    output logic prog_valid,
    input wire logic [23:0] primary_data_address,
    input wire logic data_rd,
    input wire logic data_wr,
    input wire cmbf_size_type data_size,
    input wire logic [31:0] core_write_data,
    output logic [31:0] core_read_data,
    output logic data_valid,
    input wire logic [23:0] secondary_data_address,
    input wire logic sec_rd,
    output logic [15:0] secondary_read_data,
    output logic sec_valid,
    output logic [20:0] pm_addr,
    output logic pm_rd,
    output logic pm_wr,
    output logic [15:0] pm_wdata,
    input wire logic [15:0] pm_rdata,
    output logic [23:0] dm_addr,
    output logic dm_rd,
    output logic dm_wr,
    output cmbf_size_type dm_size,
    output logic [31:0] dm_wdata,
    input wire logic [31:0] dm_rdata,
    output logic [23:0] dm2_addr,
    output logic dm2_rd,
    input wire logic [15:0] dm2_rdata,
    output logic [15:0] periph_addr,
    output logic periph_rd,
    output logic periph_wr,
    output logic [15:0] periph_wdata,
    input wire logic [15:0] periph_rdata
);
    // ==========================================================
    // Primary address decode
    cmbf_dec_if dbus();
    cmbf_decode u_decode
    (
        .dbus(dbus)
    );
    assign dbus.addr_raw = primary_data_address;
    assign dbus.size = data_size;

    // Write beats read when both strobes arrive together
    wire data_rd_q = data_rd && !data_wr;
    wire prog_rd_q = prog_rd && !prog_wr;
    wire to_periph = dbus.is_periph;
    wire dm_rd_next = data_rd_q && !to_periph;
    wire dm_wr_next = data_wr && !to_periph;
    wire pr_rd_next = data_rd_q && to_periph;
    wire pr_wr_next = data_wr && to_periph;
    // Narrow peripheral read widened with zeros in the upper half
    wire [31:0] periph_word = {16'h0000, periph_rdata};

    // ==========================================================
    // Program memory request stage
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pm_addr <= 21'h000000;
            pm_rd <= 1'b0;
            pm_wr <= 1'b0;
            pm_wdata <= 16'h0000;
        end
        else
        begin
            pm_rd <= prog_rd_q;
            pm_wr <= prog_wr;
            if (prog_rd || prog_wr)
                pm_addr <= prog_addr;
            if (prog_wr)
                pm_wdata <= core_write_data[15:0];
        end
    end

    // ==========================================================
    // Primary data request stage, memory or peripheral side
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dm_addr <= CMBF_ADDR_RST;
            dm_rd <= 1'b0;
            dm_wr <= 1'b0;
            dm_size <= CMBF_SIZE_WORD;
            dm_wdata <= CMBF_DATA_RST;
        end
        else
        begin
            dm_rd <= dm_rd_next;
            dm_wr <= dm_wr_next;
            if (dm_rd_next || dm_wr_next)
            begin
                dm_addr <= dbus.addr_eff;
                dm_size <= data_size;
            end
            if (dm_wr_next)
                dm_wdata <= core_write_data;
        end
    end

    // Peripheral side is issued in the same stage as data memory
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            periph_addr <= 16'h0000;
            periph_rd <= 1'b0;
            periph_wr <= 1'b0;
            periph_wdata <= 16'h0000;
        end
        else
        begin
            periph_rd <= pr_rd_next;
            periph_wr <= pr_wr_next;
            if (pr_rd_next || pr_wr_next)
                periph_addr <= dbus.addr_eff[15:0];
            if (pr_wr_next)
                periph_wdata <= core_write_data[15:0];
        end
    end

    // ==========================================================
    // Secondary word read of a dual read
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dm2_addr <= CMBF_ADDR_RST;
            dm2_rd <= 1'b0;
        end
        else
        begin
            dm2_rd <= sec_rd;
            if (sec_rd)
                dm2_addr <= secondary_data_address;
        end
    end

    // ==========================================================
    // Read return stage, one register per path
    // Keeping the peripheral and memory returns equally deep means
    // software never sees a latency difference between them.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prog_read_data <= 16'h0000;
            prog_valid <= 1'b0;
            core_read_data <= CMBF_DATA_RST;
            data_valid <= 1'b0;
            secondary_read_data <= 16'h0000;
            sec_valid <= 1'b0;
        end
        else
        begin
            prog_valid <= pm_rd;
            if (pm_rd)
                prog_read_data <= pm_rdata;
            data_valid <= dm_rd || periph_rd;
            if (dm_rd)
                core_read_data <= dm_rdata;
            else if (periph_rd)
                core_read_data <= periph_word;
            sec_valid <= dm2_rd;
            if (dm2_rd)
                secondary_read_data <= dm2_rdata;
        end
    end

    // ==========================================================
    // Checks
    sequence prog_issue_s;
        prog_rd && !prog_wr;
    endsequence
    sequence dm_read_s;
        data_rd && !data_wr && !to_periph;
    endsequence
    sequence pr_read_s;
        data_rd && !data_wr && to_periph;
    endsequence

    prog_fetch_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        prog_issue_s |=> pm_rd && pm_addr == $past(prog_addr)
        ##1 prog_valid && prog_read_data == $past(pm_rdata))
        else $error("program fetch not carried");
    prog_write_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        prog_wr |=> pm_wr && !pm_rd
        && pm_wdata == $past(core_write_data[15:0]))
        else $error("program write data wrong");
    data_read_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        dm_read_s |=> dm_rd && !periph_rd
        ##1 data_valid && core_read_data == $past(dm_rdata))
        else $error("data memory read wrong");
    data_write_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        data_wr && !to_periph |=> dm_wr
        && dm_wdata == $past(core_write_data))
        else $error("data memory write wrong");
    size_pass_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        dm_read_s |=> dm_size == $past(data_size))
        else $error("access size not passed");
    dual_read_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        sec_rd |=> dm2_rd && dm2_addr == $past(secondary_data_address)
        ##1 sec_valid && secondary_read_data == $past(dm2_rdata))
        else $error("secondary read wrong");
    periph_lat_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        pr_read_s |=> periph_rd && !dm_rd ##1 data_valid
        && core_read_data == {16'h0000, $past(periph_rdata)})
        else $error("peripheral read latency wrong");
    periph_write_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        data_wr && to_periph |=> periph_wr && !dm_wr
        && periph_wdata == $past(core_write_data[15:0]))
        else $error("peripheral write wrong");
    byte_msb_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (data_rd || data_wr) && data_size == CMBF_SIZE_BYTE
        && !to_periph |=> !dm_addr[CMBF_ADDR_MSB])
        else $error("byte address top bit set");
    // Every primary request lands on exactly one target, never none
    route_excl_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (data_rd || data_wr)
        |=> (dm_rd || dm_wr) != (periph_rd || periph_wr))
        else $error("access routed to both or no targets");
    // Window hit judged on the raw address, independent of the decoder
    win_route_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (data_rd || data_wr)
        && ((primary_data_address & CMBF_PERIPH_MASK) == CMBF_PERIPH_BASE)
        |=> (periph_rd || periph_wr) && !dm_rd && !dm_wr)
        else $error("window access not sent to peripherals");
endmodule

// File: tb/cmbf_mem_model.sv
/*
 Far-side model: program, data and secondary memories plus peripheral regs.
 Assumes the fabric's read strobes are one-cycle pulses.
*/
`timescale 1ns/100ps
module cmbf_mem_model
(
    input wire logic mclk,
    input wire logic [20:0] pm_addr,
    input wire logic pm_rd,
    input wire logic [23:0] dm_addr,
    input wire logic dm_rd,
    input wire logic [23:0] dm2_addr,
    input wire logic dm2_rd,
    input wire logic [15:0] periph_addr,
    input wire logic periph_rd,
    output logic [15:0] pm_rdata,
    output logic [31:0] dm_rdata,
    output logic [15:0] dm2_rdata,
    output logic [15:0] periph_rdata
);
    logic [15:0] pv, sv, fv;
    logic [15:0] pl = 16'h0000;
    logic [15:0] sl = 16'h0000;
    logic [15:0] fl = 16'h0000;
    logic [31:0] dv;
    logic [31:0] dl = 32'h00000000;
    // ==========================================================
    // Contents are a fixed hash of the address
    assign pv = pm_addr[15:0] ^ 16'h5A5A;
    assign dv = {dm_addr[15:0], ~dm_addr[15:0]};
    assign sv = dm2_addr[15:0] ^ 16'hC3C3;
    assign fv = ~periph_addr;
    // Data only in the strobe cycle; idle shows the inverse, never stale
    assign pm_rdata = pm_rd ? pv : ~pl;
    assign dm_rdata = dm_rd ? dv : ~dl;
    assign dm2_rdata = dm2_rd ? sv : ~sl;
    assign periph_rdata = periph_rd ? fv : ~fl;
    // Last presented values
    always_ff @(posedge mclk)
    begin
        pl <= pm_rd ? pv : pl;
        dl <= dm_rd ? dv : dl;
        sl <= dm2_rd ? sv : sl;
        fl <= periph_rd ? fv : fl;
    end
endmodule

// File: tb/tb.sv
/*
 Self-checking bench for the core memory bus fabric.
 Assumes the memory model answers in the cycle of each read strobe.
*/
`timescale 1ns/100ps
module tb;
    import cmbf_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic prog_rd = 1'b0, prog_wr = 1'b0, data_rd = 1'b0, data_wr = 1'b0;
    logic sec_rd = 1'b0, prog_valid, data_valid, sec_valid;
    logic [20:0] prog_addr = 21'h000000, pm_addr;
    logic [23:0] primary_data_address = 24'h000000, dm_addr, dm2_addr;
    logic [23:0] secondary_data_address = 24'h000000;
    cmbf_size_type data_size = CMBF_SIZE_WORD, dm_size;
    logic [31:0] core_write_data = 32'h00000000, core_read_data;
    logic [31:0] dm_wdata, dm_rdata;
    logic [15:0] prog_read_data, secondary_read_data, pm_wdata, pm_rdata;
    logic [15:0] dm2_rdata, periph_addr, periph_wdata, periph_rdata;
    logic pm_rd, pm_wr, dm_rd, dm_wr, dm2_rd, periph_rd, periph_wr;
    int err_count = 0;
    int comparisons = 0;
    cmbf_fabric i_cmbf_fabric
    (
        .mclk(mclk),
        .rst_b(rst_b),
        .prog_addr(prog_addr),
        .prog_rd(prog_rd),
        .prog_wr(prog_wr),
        .prog_read_data(prog_read_data),
        .prog_valid(prog_valid),
        .primary_data_address(primary_data_address),
        .data_rd(data_rd),
        .data_wr(data_wr),
        .data_size(data_size),
        .core_write_data(core_write_data),
        .core_read_data(core_read_data),
        .data_valid(data_valid),
        .secondary_data_address(secondary_data_address),
        .sec_rd(sec_rd),
        .secondary_read_data(secondary_read_data),
        .sec_valid(sec_valid),
        .pm_addr(pm_addr),
        .pm_rd(pm_rd),
        .pm_wr(pm_wr),
        .pm_wdata(pm_wdata),
        .pm_rdata(pm_rdata),
        .dm_addr(dm_addr),
        .dm_rd(dm_rd),
        .dm_wr(dm_wr),
        .dm_size(dm_size),
        .dm_wdata(dm_wdata),
        .dm_rdata(dm_rdata),
        .dm2_addr(dm2_addr),
        .dm2_rd(dm2_rd),
        .dm2_rdata(dm2_rdata),
        .periph_addr(periph_addr),
        .periph_rd(periph_rd),
        .periph_wr(periph_wr),
        .periph_wdata(periph_wdata),
        .periph_rdata(periph_rdata)
    );
    cmbf_mem_model i_cmbf_mem_model
    (
        .mclk(mclk),
        .pm_addr(pm_addr),
        .pm_rd(pm_rd),
        .dm_addr(dm_addr),
        .dm_rd(dm_rd),
        .dm2_addr(dm2_addr),
        .dm2_rd(dm2_rd),
        .periph_addr(periph_addr),
        .periph_rd(periph_rd),
        .pm_rdata(pm_rdata),
        .dm_rdata(dm_rdata),
        .dm2_rdata(dm2_rdata),
        .periph_rdata(periph_rdata)
    );
    // ==========================================================
    // Clock, reset and watchdog
    initial
    begin
        forever #10 mclk = ~mclk;
    end
    initial
    begin
        #100000;
        err_count++;
        tally_and_finish();
    end
    task automatic chk(input string nm, input logic [31:0] got, exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %s exp %h got %h", nm, exp, got);
        end
    endtask
    // Next edge takes the request; strobes drop so each stays a pulse
    task automatic step;
        @(posedge mclk);
        {prog_rd, prog_wr, data_rd, data_wr, sec_rd} <= 5'h00;
        #1;
    endtask
    task automatic fetch_top;
        @(posedge mclk);
        prog_addr <= 21'h1F1234;
        prog_rd <= 1'b1;
        step();
        chk("pm_rd", pm_rd, 1);
        chk("pm_addr", pm_addr, 21'h1F1234);
        step();
        chk("prog_valid", prog_valid, 1);
        chk("prog_data", prog_read_data, 16'h1234 ^ 16'h5A5A);
    endtask
    task automatic prog_write;
        @(posedge mclk);
        prog_addr <= 21'h000155;
        core_write_data <= 32'hFFFF1234;
        // Fetch strobe alongside the write must be dropped
        {prog_wr, prog_rd} <= 2'h3;
        step();
        chk("pm_wr", pm_wr, 1);
        chk("pm_rd_drop", pm_rd, 0);
        chk("pm_wdata", pm_wdata, 16'h1234);
        chk("pm_addr_w", pm_addr, 21'h000155);
    endtask
    task automatic dual_read;
        @(posedge mclk);
        primary_data_address <= 24'hFE8000;
        secondary_data_address <= 24'hABCDEF;
        data_size <= CMBF_SIZE_LONG;
        {data_rd, sec_rd} <= 2'h3;
        step();
        chk("dm_addr", dm_addr, 24'hFE8000);
        chk("dm2_rd", dm2_rd, 1);
        chk("dm2_addr", dm2_addr, 24'hABCDEF);
        step();
        chk("rdata", core_read_data, 32'h80007FFF);
        chk("sec_valid", sec_valid, 1);
        chk("sec_data", secondary_read_data, 16'hCDEF ^ 16'hC3C3);
    endtask
    task automatic long_write_refused_read;
        @(posedge mclk);
        primary_data_address <= 24'hFFFFFC;
        core_write_data <= 32'hDEADBEEF;
        {data_wr, data_rd} <= 2'h3;
        step();
        chk("dm_wr", dm_wr, 1);
        chk("dm_rd_drop", dm_rd, 0);
        chk("dm_wdata", dm_wdata, 32'hDEADBEEF);
        chk("dm_size", dm_size, CMBF_SIZE_LONG);
        step();
        chk("no_valid", data_valid, 0);
    endtask
    task automatic byte_clamp;
        @(posedge mclk);
        primary_data_address <= 24'h812345;
        data_size <= CMBF_SIZE_BYTE;
        data_rd <= 1'b1;
        step();
        chk("byte_addr", dm_addr, 24'h012345);
        chk("byte_size", dm_size, CMBF_SIZE_BYTE);
        step();
        chk("byte_data", core_read_data, 32'h2345DCBA);
    endtask
    task automatic periph_access;
        @(posedge mclk);
        primary_data_address <= 24'h00F0AB;
        data_size <= CMBF_SIZE_WORD;
        core_write_data <= 32'h55559ABC;
        data_wr <= 1'b1;
        step();
        chk("periph_wr", periph_wr, 1);
        chk("dm_wr_off", dm_wr, 0);
        chk("periph_wd", periph_wdata, 16'h9ABC);
        // Byte access above the window folds into it after the clamp
        @(posedge mclk);
        primary_data_address <= 24'h80F0AB;
        data_size <= CMBF_SIZE_BYTE;
        data_rd <= 1'b1;
        step();
        chk("periph_rd", periph_rd, 1);
        chk("dm_rd_off", dm_rd, 0);
        chk("periph_addr", periph_addr, 16'hF0AB);
        step();
        chk("p_valid", data_valid, 1);
        chk("p_rdata", core_read_data, 32'h00000F54);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        #1;
        chk("rst_size", dm_size, CMBF_SIZE_WORD);
        fetch_top();
        prog_write();
        dual_read();
        long_write_refused_read();
        byte_clamp();
        periph_access();
        tally_and_finish();
    end
endmodule
